// File: bench/sat_translator_model.sv
/* sat_translator_model: stepper translator and brake seen from the axis.
   assumes step, dir and brake come from the axis on clk_in. */
`timescale 1ns/1ns
module sat_translator_model (
    input wire logic clk_in,
    input wire logic step_in,
    input wire logic dir_in,
    input wire logic brake_in
);
    int net_steps = 0;
    int braked_steps = 0;
    always @(posedge clk_in) begin
        if (step_in === 1'b1) begin
            net_steps <= net_steps + (dir_in ? 1 : -1);
            braked_steps <= braked_steps + (brake_in ? 1 : 0);
        end
    end
endmodule : sat_translator_model

// File: bench/step_axis_trajectory_brake_timing_tb.sv
/* step_axis_trajectory_brake_timing_tb: self-checking bench for sat_axis_top.
   assumes a 10-cycle ms tick and a translator model on the step side. */
`timescale 1ns/1ns
module step_axis_trajectory_brake_timing_tb;
    import sat_pkg::*;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic cfg_apply_in = 1'b0;
    logic auto_brake_en_in = 1'b1;
    logic move_start_in = 1'b0;
    sat_cfg_t cfg_in = '0;
    sat_cfg_t cur = '0;
    sat_cfg_t g;
    sat_cfg_t bad;
    logic [FREQ_W-1:0] max_speed_limit = 20'h7a120;
    logic [FREQ_W-1:0] fmin = 20'h01388;
    logic [ACC_W-1:0] alo = 24'h0003e8;
    logic [ACC_W-1:0] acf = 24'h0f4240;
    logic signed [POS_W-1:0] target_pos_in = '0;
    logic step_pulse_out, dir_out, brake_engage_out, busy_out, stop_stage_out, cfg_error_out;
    logic [FRQM_W-1:0] freq_mhz_out;
    logic [FRQM_W-1:0] lastf;
    logic signed [POS_W-1:0] position_out;
    logic [31:0] seed = 32'h00000061;
    int errors = 0;
    int samples_checked = 0;
    int mpos = 0;
    logic saw_stop;
    always #50 clk_in = ~clk_in;
    sat_axis_top #(.MS_CYCLES_P(10)) u_sat_axis_top (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .cfg_in(cfg_in), .cfg_apply_in(cfg_apply_in), .max_speed_limit_in(max_speed_limit),
        .range_min_freq_in(fmin), .accel_lower_in(alo), .accel_config_in(acf),
        .auto_brake_en_in(auto_brake_en_in), .move_start_in(move_start_in),
        .target_pos_in(target_pos_in), .step_pulse_out(step_pulse_out), .dir_out(dir_out),
        .brake_engage_out(brake_engage_out), .busy_out(busy_out),
        .stop_stage_out(stop_stage_out), .cfg_error_out(cfg_error_out),
        .freq_mhz_out(freq_mhz_out), .position_out(position_out));
    sat_translator_model u_sat_translator_model (.clk_in(clk_in), .step_in(step_pulse_out),
        .dir_in(dir_out), .brake_in(brake_engage_out));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic signed [31:0] exp,
                         input logic signed [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %0d seen %0d", what, exp, got);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : tally_and_finish
    function automatic logic cfg_ok(input sat_cfg_t c);
        int a;
        a = int'(c.accel_setting);
        cfg_ok = c.start_stop_frequency <= ((max_speed_limit < 4000) ? int'(max_speed_limit) : 4000);
        cfg_ok &= c.accel_in_ms ? (a >= acf && a <= 5000) : (a >= alo && a <= acf);
        cfg_ok &= c.lower_soft_limit <= c.upper_soft_limit && c.lower_soft_limit >= -16777216;
        cfg_ok &= c.upper_soft_limit <= 16777215 && c.lower_soft_limit <= 16777215;
        cfg_ok &= c.brake_on_ms >= -1000 && c.brake_on_ms <= 1000;
        cfg_ok &= c.brake_off_ms >= -1000 && c.brake_off_ms <= 1000 && c.stop_dwell_ms <= 1000;
    endfunction : cfg_ok
    task automatic apply(input sat_cfg_t c);
        @(posedge clk_in);
        cfg_in <= c;
        cfg_apply_in <= 1'b1;
        @(posedge clk_in);
        cfg_apply_in <= 1'b0;
        @(negedge clk_in);
        check("cfg_error_out", !cfg_ok(c), cfg_error_out);
        if (cfg_ok(c)) cur = c;
    endtask : apply
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xorshift
    task automatic move();
        int tgt, lo, hi, ex, n0, b0, k, ss, n, e;
        logic lim;
        seed = xorshift(seed);
        tgt = int'(seed % 32'h000000f1) - 120;
        lim = cur.upper_soft_limit != 0 || cur.lower_soft_limit != 0;
        lo = lim ? cur.lower_soft_limit : -16777216;
        hi = lim ? cur.upper_soft_limit : 16777215;
        ex = (tgt < lo) ? lo : ((tgt > hi) ? hi : tgt);
        ss = (cur.start_stop_frequency == 0) ? fmin : cur.start_stop_frequency;
        n0 = u_sat_translator_model.net_steps;
        b0 = u_sat_translator_model.braked_steps;
        saw_stop = 1'b0;
        @(posedge clk_in);
        move_start_in <= 1'b1;
        target_pos_in <= tgt[POS_W-1:0];
        @(posedge clk_in);
        move_start_in <= 1'b0;
        @(negedge clk_in);
        for (k = 0; k < 30000 && busy_out === 1'b1; k++) begin
            if (step_pulse_out === 1'b1) lastf = freq_mhz_out;
            if (stop_stage_out === 1'b1) saw_stop = 1'b1;
            @(negedge clk_in);
        end
        check("busy_out", 0, busy_out);
        check("position_out", ex, position_out);
        check("net steps", ex - mpos, u_sat_translator_model.net_steps - n0);
        if (cur.stop_dwell_ms != 0 && ex != mpos) begin
            check("end rate", ss * 1000, lastf);
            check("stop stage", 1, saw_stop);
        end
        if (auto_brake_en_in && cur.brake_on_ms < 0) begin
            // anticipation in pulses at start/stop rate, capped by the dwell
            n = (ex > mpos) ? ex - mpos : mpos - ex;
            e = ss * int'(-cur.brake_on_ms) / 1000;
            k = ss * int'(cur.stop_dwell_ms) / 1000;
            e = (e < k) ? e : k;
            e = (e < n) ? e : n;
            check("braked steps", e, u_sat_translator_model.braked_steps - b0);
        end
        mpos = ex;
        repeat (2) @(negedge clk_in);
        check("brake_engage_out", auto_brake_en_in, brake_engage_out);
    endtask : move
    initial begin
        repeat (95000) @(posedge clk_in);
        errors++;
        tally_and_finish();
    end
    initial begin
        g = '{20'h00fa0, 24'h0f4240, 1'b0, 32'sh50, -32'sh3c, 16'sh2, -16'sh1, 16'h0};
        repeat (5) @(posedge clk_in);
        rst_n_in <= 1'b1;
        @(negedge clk_in);
        check("reset position", 0, position_out);
        check("reset busy", 0, busy_out);
        for (int i = 0; i < 8; i++) begin
            bad = g;
            case (i)
                0: bad.start_stop_frequency = 20'h00fa1;
                1: bad.accel_setting = 24'h0003e7;
                2: bad.lower_soft_limit = 32'sh51;
                3: bad.upper_soft_limit = 32'sh01000000;
                4: bad.brake_on_ms = -16'sh3e9;
                5: bad.brake_off_ms = 16'sh3e9;
                6: bad.stop_dwell_ms = 16'h03e9;
                default: bad.accel_in_ms = 1'b1;
            endcase
            apply(bad);
        end
        apply(g);
        repeat (3) move();
        @(posedge clk_in);
        auto_brake_en_in <= 1'b0;
        g.start_stop_frequency = 20'h0;
        g.upper_soft_limit = 32'sh0;
        g.lower_soft_limit = 32'sh0;
        g.brake_on_ms = -16'sh1;
        g.stop_dwell_ms = 16'h2;
        apply(g);
        move();
        check("steps under brake", 0, u_sat_translator_model.braked_steps);
        @(posedge clk_in);
        auto_brake_en_in <= 1'b1;
        move();
        // ms unit: ramp time window runs from the configured value to 5000 ms
        @(posedge clk_in);
        acf <= 24'h0003e8;
        g.accel_in_ms = 1'b1;
        g.accel_setting = 24'h001388;
        apply(g);
        g.accel_setting = 24'h001389;
        apply(g);
        tally_and_finish();
    end
endmodule : step_axis_trajectory_brake_timing_tb

// File: pkg/sat_pkg.sv
/*
 * sat_pkg: constants, configuration carrier and state encoding for the
 * step axis trajectory and brake timing block.
 * assumes a single 10 MHz clock; all widths are fixed.
 */
package sat_pkg;

    localparam int FREQ_W = 20;
    localparam int ACC_W  = 24;
    localparam int POS_W  = 25;
    localparam int FRQM_W = 30;
    localparam int PH_W   = 35;

    localparam int CLK_HZ    = 32'h0098_9680;
    localparam int TICK_MS   = 32'h0000_0001;
    localparam int MS_CYCLES = CLK_HZ / 32'h0000_03e8 * TICK_MS;

    localparam logic [FREQ_W-1:0]     SS_CAP_HZ    = 20'h00fa0;
    localparam logic [ACC_W-1:0]      RAMP_MAX_MS  = 24'h001388;
    localparam logic signed [15:0]    BRAKE_MAX_MS = 16'sh03e8;
    localparam logic [15:0]           DWELL_MAX_MS = 16'h03e8;
    localparam logic [FRQM_W-1:0]     MHZ_PER_HZ   = 30'h000003e8;
    localparam logic [46:0]           DIV1K_MUL    = 47'h00000000419;
    localparam int                    DIV1K_SH     = 20;
    localparam logic [5:0]            DIV_STEPS    = 6'h20;
    localparam logic [PH_W-1:0]       PHASE_WRAP   = 35'h2_540b_e400;
    localparam logic signed [POS_W-1:0] POS_MAX    = 25'sh0ff_ffff;
    localparam logic signed [POS_W-1:0] POS_MIN    = 25'sh100_0000;
    localparam logic signed [POS_W-1:0] POS_ONE    = 25'sh000_0001;

    typedef struct packed {
        logic [FREQ_W-1:0] start_stop_frequency;
        logic [ACC_W-1:0]  accel_setting;
        logic              accel_in_ms;
        logic signed [31:0] upper_soft_limit;
        logic signed [31:0] lower_soft_limit;
        logic signed [15:0] brake_on_ms;
        logic signed [15:0] brake_off_ms;
        logic [15:0]       stop_dwell_ms;
    } sat_cfg_t;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'h0,
        ST_RELEASE = 3'h1,
        ST_SLOPE   = 3'h2,
        ST_RUN     = 3'h3,
        ST_BRAKE   = 3'h4
    } sat_state_t;

endpackage : sat_pkg

// File: verilog/sat_axis_top.sv
/*
 * sat_axis_top: one step axis channel. checks and holds trajectory and
 * brake settings, ramps the pulse rate, counts position, runs the stop
 * stage and times the brake output.
 * assumes all inputs come from logic on clk_in; the translator takes
 * one step per step_pulse_out cycle with dir_out steady around it.
 */
`timescale 1ns/1ns

module sat_axis_top #(
    parameter int MS_CYCLES_P = sat_pkg::MS_CYCLES
) (
    input  logic                          clk_in,
    input  logic                          rst_n_in,
    input  sat_pkg::sat_cfg_t             cfg_in,
    input  logic                          cfg_apply_in,
    input  logic [sat_pkg::FREQ_W-1:0]    max_speed_limit_in,
    input  logic [sat_pkg::FREQ_W-1:0]    range_min_freq_in,
    input  logic [sat_pkg::ACC_W-1:0]     accel_lower_in,
    input  logic [sat_pkg::ACC_W-1:0]     accel_config_in,
    input  logic                          auto_brake_en_in,
    input  logic                          move_start_in,
    input  logic signed [sat_pkg::POS_W-1:0] target_pos_in,
    output logic                          step_pulse_out,
    output logic                          dir_out,
    output logic                          brake_engage_out,
    output logic                          busy_out,
    output logic                          stop_stage_out,
    output logic                          cfg_error_out,
    output logic [sat_pkg::FRQM_W-1:0]    freq_mhz_out,
    output logic signed [sat_pkg::POS_W-1:0] position_out
);
    import sat_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic [FRQM_W-1:0] hz_to_mhz(input logic [FREQ_W-1:0] hz);
        return FRQM_W'(hz) * MHZ_PER_HZ;
    endfunction : hz_to_mhz

    // pulses issued at hz during ms milliseconds, /1000 by multiply and shift
    function automatic logic [POS_W-1:0] mul_div1k(input logic [FREQ_W-1:0] hz,
                                                 input logic [15:0] ms);
        logic [46:0] p;
        p = 47'(hz) * 47'(ms) * DIV1K_MUL;
        return p[DIV1K_SH +: POS_W];
    endfunction : mul_div1k

    function automatic logic [15:0] abs_ms(input logic signed [15:0] v);
        return (v < 0) ? 16'(-v) : 16'(v);
    endfunction : abs_ms

    function automatic logic cfg_ok(input sat_cfg_t c,
                                    input logic [FREQ_W-1:0] max_speed_limit,
                                    input logic [ACC_W-1:0] amin,
                                    input logic [ACC_W-1:0] acfg);
        logic [FREQ_W-1:0] cap;
        logic              ok;
        cap = (max_speed_limit < SS_CAP_HZ) ? max_speed_limit : SS_CAP_HZ;
        ok  = (c.start_stop_frequency <= cap);
        if (c.accel_in_ms) begin
            ok = ok && (c.accel_setting >= acfg) && (c.accel_setting <= RAMP_MAX_MS);
        end else begin
            ok = ok && (c.accel_setting >= amin) && (c.accel_setting <= acfg);
        end
        ok = ok && (c.lower_soft_limit <= c.upper_soft_limit);
        ok = ok && (c.lower_soft_limit >= 32'(POS_MIN)) && (c.upper_soft_limit <= 32'(POS_MAX));
        ok = ok && (c.upper_soft_limit >= 32'(POS_MIN)) && (c.lower_soft_limit <= 32'(POS_MAX));
        ok = ok && (abs_ms(c.brake_on_ms) <= 16'(BRAKE_MAX_MS));
        ok = ok && (abs_ms(c.brake_off_ms) <= 16'(BRAKE_MAX_MS));
        ok = ok && (c.stop_dwell_ms <= DWELL_MAX_MS);
        return ok;
    endfunction : cfg_ok

    ////////////////////////////////////////////////////////////////////////
    // declarations

    sat_cfg_t                 cfg_ff;
    logic                     cfg_err_ff;
    sat_state_t               state_ff;
    sat_state_t               nxt_state;
    logic [31:0]              cyc_ff;
    logic [15:0]              ms_cnt_ff;
    logic                     ms_tick;
    logic signed [POS_W-1:0]  position_ff;
    logic signed [POS_W-1:0]  tgt_ff;
    logic                     dir_ff;
    logic                     step_ff;
    logic                     busy_ff;
    logic                     brake_ff;
    logic [FRQM_W-1:0]        freq_ff;
    logic [PH_W-1:0]          phase_ff;
    logic [POS_W-1:0]         ramp_pulses_ff;
    logic                     decel_ff;
    logic                     stop_stage_ff;
    logic [ACC_W:0]           div_rem_ff;
    logic [31:0]              div_quo_ff;
    logic [5:0]               div_cnt_ff;

    logic [FREQ_W-1:0]        ss_hz;
    logic [FRQM_W-1:0]        ss_m;
    logic [FRQM_W-1:0]        max_speed_limit_m;
    logic [FRQM_W-1:0]        slope;
    logic [31:0]              numer;
    logic                     lim_en;
    logic signed [POS_W-1:0]  hi_eff;
    logic signed [POS_W-1:0]  lo_eff;
    logic signed [POS_W-1:0]  tgt_clamp;
    logic                     start_ok;
    logic [POS_W:0]           rem_pulses;
    logic [POS_W-1:0]         dwell_pulses;
    logic [POS_W-1:0]         ant_raw;
    logic [POS_W-1:0]         ant_pulses;
    logic                     arrived;
    logic                     in_span;
    logic                     decel_go;
    logic                     fire;
    logic [PH_W-1:0]          phase_sum;
    logic [ACC_W:0]           div_trial;
    logic [31:0]              ramp_up;
    logic                     act_neg;
    logic                     rel_neg;

    ////////////////////////////////////////////////////////////////////////
    // derived settings

    assign ss_hz  = (cfg_ff.start_stop_frequency == '0) ? range_min_freq_in
                  : cfg_ff.start_stop_frequency;
    assign ss_m   = hz_to_mhz(ss_hz);
    assign max_speed_limit_m = hz_to_mhz(max_speed_limit_in);
    assign numer  = (max_speed_limit_m > ss_m) ? 32'(max_speed_limit_m - ss_m) : 32'h0000_0000;
    // ms unit: slope = span / ramp time; Hz/s unit: Hz/s equals mHz per ms
    assign slope  = cfg_ff.accel_in_ms ? div_quo_ff[FRQM_W-1:0]
                  : FRQM_W'(cfg_ff.accel_setting);

    assign lim_en = !((cfg_ff.upper_soft_limit == 0) && (cfg_ff.lower_soft_limit == 0));
    assign hi_eff = lim_en ? $signed(cfg_ff.upper_soft_limit[POS_W-1:0]) : POS_MAX;
    assign lo_eff = lim_en ? $signed(cfg_ff.lower_soft_limit[POS_W-1:0]) : POS_MIN;
    assign tgt_clamp = (target_pos_in > hi_eff) ? hi_eff
                     : (target_pos_in < lo_eff) ? lo_eff : target_pos_in;
    assign start_ok  = move_start_in && (state_ff == ST_IDLE) && (tgt_clamp != position_ff);

    assign rem_pulses   = dir_ff ? ({tgt_ff[POS_W-1], tgt_ff} - {position_ff[POS_W-1], position_ff})
                                 : ({position_ff[POS_W-1], position_ff} - {tgt_ff[POS_W-1], tgt_ff});
    assign dwell_pulses = mul_div1k(ss_hz, cfg_ff.stop_dwell_ms);
    assign ant_raw      = mul_div1k(ss_hz, abs_ms(cfg_ff.brake_on_ms));
    // anticipation cannot reach back past the start of the stop stage
    assign ant_pulses   = (ant_raw < dwell_pulses) ? ant_raw : dwell_pulses;
    assign act_neg      = cfg_ff.brake_on_ms < 0;
    assign rel_neg      = cfg_ff.brake_off_ms < 0;

    assign arrived   = (position_ff == tgt_ff);
    assign in_span   = dir_ff ? (position_ff < hi_eff) : (position_ff > lo_eff);
    assign decel_go  = rem_pulses <= ({1'b0, ramp_pulses_ff} + {1'b0, dwell_pulses});
    assign phase_sum = phase_ff + PH_W'(freq_ff);
    assign fire      = (state_ff == ST_RUN) && (phase_sum >= PHASE_WRAP) && !arrived && in_span;
    assign div_trial = {div_rem_ff[ACC_W-1:0], div_quo_ff[31]};
    assign ramp_up   = 32'(freq_ff) + 32'(slope);
    assign ms_tick   = (cyc_ff == 32'(MS_CYCLES_P - 1));

    ////////////////////////////////////////////////////////////////////////
    // settings: a bad set is refused whole and the old one kept

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            cfg_ff     <= '0;
            cfg_err_ff <= 1'b0;
        end else if (cfg_apply_in) begin
            if (cfg_ok(cfg_in, max_speed_limit_in, accel_lower_in, accel_config_in)) begin
                cfg_ff     <= cfg_in;
                cfg_err_ff <= 1'b0;
            end else begin
                cfg_err_ff <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (start_ok) begin
                    nxt_state = (auto_brake_en_in && rel_neg) ? ST_RELEASE : ST_SLOPE;
                end
            end
            ST_RELEASE: begin
                if (ms_cnt_ff >= abs_ms(cfg_ff.brake_off_ms)) begin
                    nxt_state = ST_SLOPE;
                end
            end
            ST_SLOPE: begin
                if (!cfg_ff.accel_in_ms || (div_cnt_ff == DIV_STEPS)) begin
                    nxt_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (arrived) begin
                    nxt_state = (auto_brake_en_in && cfg_ff.brake_on_ms > 0) ? ST_BRAKE
                              : ST_IDLE;
                end
            end
            ST_BRAKE: begin
                if (ms_cnt_ff >= 16'(cfg_ff.brake_on_ms)) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state_ff <= ST_IDLE;
            busy_ff  <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            busy_ff  <= (nxt_state != ST_IDLE);
        end
    end

    // millisecond timer, restarted on every state change
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || (state_ff != nxt_state)) begin
            cyc_ff    <= 32'h0000_0000;
            ms_cnt_ff <= 16'h0000;
        end else if (ms_tick) begin
            cyc_ff    <= 32'h0000_0000;
            ms_cnt_ff <= ms_cnt_ff + 16'h0001;
        end else begin
            cyc_ff    <= cyc_ff + 32'h0000_0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // trajectory: slope division, ramps, stop stage

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            tgt_ff         <= '0;
            dir_ff         <= 1'b0;
            freq_ff        <= '0;
            phase_ff       <= '0;
            ramp_pulses_ff <= '0;
            decel_ff       <= 1'b0;
            stop_stage_ff  <= 1'b0;
            div_rem_ff     <= '0;
            div_quo_ff     <= 32'h0000_0000;
            div_cnt_ff     <= 6'h00;
        end else if (state_ff == ST_IDLE) begin
            freq_ff       <= '0;
            stop_stage_ff <= 1'b0;
            if (start_ok) begin
                tgt_ff     <= tgt_clamp;
                dir_ff     <= (tgt_clamp > position_ff);
                div_rem_ff <= '0;
                div_quo_ff <= numer;
                div_cnt_ff <= 6'h00;
            end
        end else if (state_ff == ST_SLOPE) begin
            // restoring divide, one quotient bit per cycle
            if (cfg_ff.accel_in_ms && (div_cnt_ff != DIV_STEPS)) begin
                div_cnt_ff <= div_cnt_ff + 6'h01;
                if (div_trial >= {1'b0, cfg_ff.accel_setting}) begin
                    div_rem_ff <= div_trial - {1'b0, cfg_ff.accel_setting};
                    div_quo_ff <= {div_quo_ff[30:0], 1'b1};
                end else begin
                    div_rem_ff <= div_trial;
                    div_quo_ff <= {div_quo_ff[30:0], 1'b0};
                end
            end
            freq_ff        <= ss_m;
            phase_ff       <= '0;
            ramp_pulses_ff <= '0;
            decel_ff       <= 1'b0;
        end else if (state_ff == ST_RUN) begin
            phase_ff <= (phase_sum >= PHASE_WRAP) ? phase_sum - PHASE_WRAP : phase_sum;
            if (fire && !decel_ff && (freq_ff < max_speed_limit_m)) begin
                ramp_pulses_ff <= ramp_pulses_ff + POS_W'(1);
            end
            decel_ff      <= decel_ff || decel_go;
            stop_stage_ff <= decel_ff && (freq_ff == ss_m);
            if (ms_tick) begin
                if (decel_ff) begin
                    freq_ff <= (freq_ff > ss_m + slope) ? freq_ff - slope : ss_m;
                end else begin
                    freq_ff <= (ramp_up < 32'(max_speed_limit_m)) ? ramp_up[FRQM_W-1:0] : max_speed_limit_m;
                end
            end
        end else begin
            freq_ff       <= '0;
            stop_stage_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // step output and position counter

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            position_ff <= '0;
            step_ff     <= 1'b0;
        end else begin
            step_ff <= fire;
            if (fire) begin
                position_ff <= dir_ff ? position_ff + POS_ONE : position_ff - POS_ONE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // brake: engaged while idle under automatic management

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            brake_ff <= 1'b0;
        end else if (!auto_brake_en_in) begin
            brake_ff <= 1'b0;
        end else if (start_ok && rel_neg) begin
            brake_ff <= 1'b0;
        end else if ((state_ff == ST_SLOPE) && (nxt_state == ST_RUN)
                     && (cfg_ff.brake_off_ms == 0)) begin
            brake_ff <= 1'b0;
        end else if ((state_ff == ST_RUN) && (cfg_ff.brake_off_ms > 0) && ms_tick
                     && !stop_stage_ff
                     && (ms_cnt_ff + 16'h0001 == 16'(cfg_ff.brake_off_ms))) begin
            brake_ff <= 1'b0;
        end else if ((state_ff == ST_RUN) && act_neg && stop_stage_ff
                     && (rem_pulses <= {1'b0, ant_pulses})) begin
            brake_ff <= 1'b1;
        end else if (state_ff == ST_IDLE) begin
            brake_ff <= 1'b1;
        end
    end

    assign step_pulse_out   = step_ff;
    assign dir_out          = dir_ff;
    assign brake_engage_out = brake_ff;
    assign busy_out         = busy_ff;
    assign stop_stage_out   = stop_stage_ff;
    assign cfg_error_out    = cfg_err_ff;
    assign freq_mhz_out     = freq_ff;
    assign position_out     = position_ff;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    AST_RUN_ENTRY_RATE:
        assert property ((state_ff == ST_SLOPE && nxt_state == ST_RUN)
                         |=> freq_ff == $past(ss_m))
        else $error("run does not begin at start/stop rate");
    AST_ZERO_SS_RANGE:
        assert property ((state_ff == ST_RUN && $past(state_ff) == ST_SLOPE
                          && cfg_ff.start_stop_frequency == '0)
                         |-> freq_ff == hz_to_mhz(range_min_freq_in))
        else $error("zero start/stop rate did not use range minimum");
    AST_BAD_CFG_KEPT:
        assert property ((cfg_apply_in
                          && !cfg_ok(cfg_in, max_speed_limit_in, accel_lower_in, accel_config_in))
                         |=> cfg_err_ff && cfg_ff == $past(cfg_ff))
        else $error("out of range settings were taken");
    AST_DECEL_FLOOR:
        assert property ((state_ff == ST_RUN && ms_tick && decel_ff && nxt_state == ST_RUN)
                         |=> freq_ff >= $past(ss_m) && freq_ff <= $past(freq_ff))
        else $error("deceleration left the start/stop floor");
    AST_UP_LIMIT:
        assert property ((step_ff && dir_ff) |-> position_ff <= hi_eff)
        else $error("step past upper limit");
    AST_LO_LIMIT:
        assert property ((step_ff && !dir_ff) |-> position_ff >= lo_eff)
        else $error("step past lower limit");
    AST_NO_AUTO_BRAKE:
        assert property (!auto_brake_en_in |=> !brake_engage_out)
        else $error("brake driven without automatic management");
    AST_LATE_ENGAGE:
        assert property ((state_ff == ST_RUN && nxt_state == ST_BRAKE)
                         |=> !brake_ff [*2])
        else $error("brake engaged before its delay");
    AST_EARLY_RELEASE:
        assert property ((start_ok && auto_brake_en_in && rel_neg)
                         |=> !brake_ff && state_ff == ST_RELEASE)
        else $error("brake not released ahead of motion");
    AST_STEP_COUNT:
        assert property (step_ff |-> position_ff == ($past(dir_ff) ? $past(position_ff) + POS_ONE
                                                                   : $past(position_ff) - POS_ONE))
        else $error("position does not follow step");
    AST_STAGE_RATE:
        assert property ((stop_stage_ff && state_ff == ST_RUN && $stable(ss_m)) |-> freq_ff == ss_m)
        else $error("stop stage not at start/stop rate");

endmodule : sat_axis_top
